// File: bench/bus_master_model.sv
// bus master model that drives the command bus and owns the data bus in write data cycles
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input wire logic clk_in,
  // command to the port
  output logic [sram_port_pkg::ADDR_W-1:0] addr_out,
  output logic [2:0] sel_out,
  output logic adv_out,
  output logic rw_out,
  output logic [sram_port_pkg::LANES-1:0] bw_n_out,
  output logic [3:0] ctl_out,
  // data bus
  input wire logic [sram_port_pkg::DATA_W-1:0] dq_in,
  input wire logic dq_oe_in,
  output logic [sram_port_pkg::DATA_W-1:0] bus_out
);
  logic [sram_port_pkg::DATA_W-1:0] wd_reg;
  logic [sram_port_pkg::DATA_W-1:0] last_reg;
  logic active_reg;
  logic wr_burst_reg;
  logic data_phase_reg;
  logic run;

  // ****************************************************************
  // bus ownership
  // ****************************************************************
  // held or sleeping edges change only the released bus pattern on this side
  assign run = !ctl_out[3] && !ctl_out[0];
  // a released bus shows a changing pattern, never the last value
  assign bus_out = dq_oe_in ? dq_in : (data_phase_reg ? wd_reg : ~last_reg);

  initial begin
    addr_out = 19'h0;
    sel_out = 3'h6;
    adv_out = 1'b0;
    rw_out = 1'b1;
    bw_n_out = 2'h3;
    ctl_out = 4'h0;
    wd_reg = 18'h0;
    last_reg = 18'h0;
    active_reg = 1'b0;
    wr_burst_reg = 1'b0;
    data_phase_reg = 1'b0;
  end

  // data follows its write command or burst write cycle by one run edge
  always @(posedge clk_in) begin
    last_reg <= bus_out;
    if (run && !adv_out) begin
      active_reg <= (sel_out == 3'h2);
      wr_burst_reg <= !rw_out;
      data_phase_reg <= (sel_out == 3'h2) && !rw_out;
    end else if (run) begin
      data_phase_reg <= active_reg && wr_burst_reg;
    end
  end

  // ****************************************************************
  // command entry, called off the falling edge
  // ****************************************************************
  task automatic put(input logic a, input logic [2:0] s, input logic w, input logic [1:0] b,
    input logic [18:0] ad, input logic [17:0] d, input logic [3:0] c);
    adv_out = a;
    sel_out = s;
    rw_out = w;
    bw_n_out = b;
    addr_out = ad;
    wd_reg = d;
    ctl_out = c;
  endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the late-write memory port
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic burst_advance;
    logic [2:0] sel;
    logic rw;
    logic [1:0] bw;
    logic [18:0] addr;
    logic [17:0] wd;
    logic [3:0] ctl;
    logic eoe;
    logic [17:0] edq;
  } row_t;

  logic clk_in;
  logic sys_rst_in;
  logic [18:0] addr;
  logic [2:0] sel;
  logic burst_advance;
  logic rw;
  logic [1:0] bw_n;
  logic [3:0] ctl;
  logic [17:0] bus;
  logic [17:0] dq_out;
  logic dq_oe_out;
  int fails;
  int checks;
  int cycles;
  row_t rows[$];

  bus_master_model u_bus_master_model (
    .clk_in(clk_in),
    .addr_out(addr),
    .sel_out(sel),
    .adv_out(burst_advance),
    .rw_out(rw),
    .bw_n_out(bw_n),
    .ctl_out(ctl),
    .dq_in(dq_out),
    .dq_oe_in(dq_oe_out),
    .bus_out(bus)
  );

  sram_late_write_port u_sram_late_write_port (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .addr_in(addr),
    .chip_sel_0_n_in(sel[2]),
    .chip_sel_1_in(sel[1]),
    .chip_sel_2_n_in(sel[0]),
    .advance_or_load_in(burst_advance),
    .read_write_n_in(rw),
    .byte_write_n_in(bw_n),
    .clock_hold_n_in(ctl[3]),
    .output_enable_n_in(ctl[1]),
    .linear_order_sel_n_in(ctl[2]),
    .sleep_request_in(ctl[0]),
    .dq_in(bus),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out)
  );

  // ****************************************************************
  // clock, timeout and reporting
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic final_report();
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 500) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic r(input logic a, input logic [2:0] s, input logic w, input logic [1:0] b,
    input logic [18:0] ad, input logic [17:0] d, input logic [3:0] c, input logic eo,
    input logic [17:0] eq);
    rows.push_back('{a, s, w, b, ad, d, c, eo, eq});
  endtask

  // one cycle: command off the falling edge, outputs looked at on the next falling edge
  task automatic step(input row_t x);
    u_bus_master_model.put(x.burst_advance, x.sel, x.rw, x.bw, x.addr, x.wd, x.ctl);
    @(negedge clk_in);
    check({18'h0, dq_oe_out}, {18'h0, x.eoe});
    if (x.eoe) check({1'h0, dq_out}, {1'h0, x.edq});
  endtask

  // ****************************************************************
  // cycle table and hand-written cases
  // ****************************************************************
  initial begin
    sys_rst_in = 1'b1;
    fails = 0;
    checks = 0;
    cycles = 0;
    // back to back writes and reads, byte lanes, abort
    r(0, 3'h2, 0, 2'h0, 19'h10, 18'h0, 4'h0, 0, 18'h0);
    r(0, 3'h2, 0, 2'h0, 19'h11, 18'h3a5a5, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h10, 18'h15a5a, 4'h0, 1, 18'h3a5a5);
    r(0, 3'h2, 1, 2'h0, 19'h11, 18'h0, 4'h0, 1, 18'h15a5a);
    r(0, 3'h2, 0, 2'h2, 19'h10, 18'h0, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h10, 18'h3ffff, 4'h0, 1, 18'h3a5ff);
    r(0, 3'h2, 0, 2'h3, 19'h11, 18'h0, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h11, 18'h3ffff, 4'h0, 1, 18'h15a5a);
    // each select alone deselects; advance without a burst does nothing
    r(0, 3'h6, 1, 2'h0, 19'h10, 18'h0, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h10, 18'h0, 4'h0, 1, 18'h3a5ff);
    r(0, 3'h0, 1, 2'h0, 19'h10, 18'h0, 4'h0, 0, 18'h0);
    r(1, 3'h2, 0, 2'h0, 19'h11, 18'h0, 4'h0, 0, 18'h0);
    r(0, 3'h3, 1, 2'h0, 19'h10, 18'h0, 4'h0, 0, 18'h0);
    // linear write burst with junk on ignored inputs, read burst with wrap
    r(0, 3'h2, 0, 2'h0, 19'h20, 18'h0, 4'h0, 0, 18'h0);
    r(1, 3'h0, 1, 2'h0, 19'h7, 18'h100, 4'h0, 0, 18'h0);
    r(1, 3'h5, 1, 2'h0, 19'h0, 18'h101, 4'h0, 0, 18'h0);
    r(1, 3'h2, 1, 2'h0, 19'h0, 18'h102, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h21, 18'h103, 4'h0, 1, 18'h101);
    r(1, 3'h0, 0, 2'h3, 19'h0, 18'h0, 4'h0, 1, 18'h102);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h103);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h100);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h101);
    // interleaved order
    r(0, 3'h2, 1, 2'h0, 19'h21, 18'h0, 4'h4, 1, 18'h101);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h4, 1, 18'h100);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h4, 1, 18'h103);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h4, 1, 18'h102);
    // hold during a read burst and during write data
    r(0, 3'h2, 1, 2'h0, 19'h22, 18'h0, 4'h0, 1, 18'h102);
    r(1, 3'h2, 0, 2'h0, 19'h10, 18'h0, 4'h8, 1, 18'h102);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h103);
    r(0, 3'h2, 0, 2'h0, 19'h30, 18'h0, 4'h0, 0, 18'h0);
    r(1, 3'h2, 1, 2'h0, 19'h10, 18'h0abcd, 4'h8, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h30, 18'h12345, 4'h0, 1, 18'h12345);
    r(0, 3'h2, 1, 2'h0, 19'h30, 18'h0, 4'h2, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h30, 18'h0, 4'h0, 1, 18'h12345);
    // byte enables sampled per burst write cycle
    r(0, 3'h2, 0, 2'h0, 19'h22, 18'h0, 4'h0, 0, 18'h0);
    r(1, 3'h0, 1, 2'h3, 19'h0, 18'h00aaa, 4'h0, 0, 18'h0);
    r(1, 3'h0, 1, 2'h1, 19'h0, 18'h3ffff, 4'h0, 0, 18'h0);
    r(0, 3'h2, 1, 2'h0, 19'h22, 18'h3fe00, 4'h0, 1, 18'h00aaa);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h103);
    r(1, 3'h0, 0, 2'h0, 19'h0, 18'h0, 4'h0, 1, 18'h3ff00);
    repeat (12) @(negedge clk_in);
    check({18'h0, dq_oe_out}, 19'h0);
    sys_rst_in = 1'b0;
    foreach (rows[i]) step(rows[i]);
    // output enable and sleep gate the drivers between edges
    step('{1'b0, 3'h2, 1'b1, 2'h0, 19'h20, 18'h0, 4'h0, 1'b1, 18'h3ff00});
    u_bus_master_model.put(1'b1, 3'h0, 1'b0, 2'h0, 19'h0, 18'h0, 4'h2);
    #1 check({18'h0, dq_oe_out}, 19'h0);
    u_bus_master_model.put(1'b1, 3'h0, 1'b0, 2'h0, 19'h0, 18'h0, 4'h1);
    #0.5 check({18'h0, dq_oe_out}, 19'h0);
    repeat (2) @(negedge clk_in);
    step('{1'b1, 3'h0, 1'b0, 2'h0, 19'h0, 18'h0, 4'h0, 1'b1, 18'h101});
    // reset in mid-burst ends the burst but keeps the array
    sys_rst_in = 1'b1;
    step('{1'b1, 3'h0, 1'b0, 2'h0, 19'h0, 18'h0, 4'h0, 1'b0, 18'h0});
    sys_rst_in = 1'b0;
    step('{1'b1, 3'h2, 1'b1, 2'h0, 19'h11, 18'h0, 4'h0, 1'b0, 18'h0});
    step('{1'b0, 3'h2, 1'b1, 2'h0, 19'h11, 18'h0, 4'h0, 1'b1, 18'h15a5a});
    final_report();
  end
endmodule

// File: core/burst_step.sv
// burst address sequencer for the two low address bits
`timescale 1ns/1ps
module burst_step (
  // burst position
  input wire logic [1:0] start_in,
  input wire logic [1:0] step_in,
  // order select, low picks linear
  input wire logic linear_order_sel_n_in,
  // stepped low address
  output logic [1:0] addr_out
);
  always_comb begin
    if (linear_order_sel_n_in) begin
      addr_out = start_in ^ step_in;
    end else begin
      addr_out = start_in + step_in;
    end
  end
endmodule

// File: core/sram_late_write_port.sv
// synchronous burst memory with late write data and flow-through reads
`timescale 1ns/1ps
module sram_late_write_port (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // command
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr_in,
  input wire logic chip_sel_0_n_in,
  input wire logic chip_sel_1_in,
  input wire logic chip_sel_2_n_in,
  input wire logic advance_or_load_in,
  input wire logic read_write_n_in,
  input wire logic [sram_port_pkg::LANES-1:0] byte_write_n_in,
  input wire logic clock_hold_n_in,
  // static and asynchronous controls
  input wire logic output_enable_n_in,
  input wire logic linear_order_sel_n_in,
  input wire logic sleep_request_in,
  // data bus
  input wire logic [sram_port_pkg::DATA_W-1:0] dq_in,
  output logic [sram_port_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out
);
  // ****************************************************************
  // state and decode
  // ****************************************************************
  sram_port_pkg::port_state_t st_reg;
  sram_port_pkg::port_state_t st_next;
  sram_port_pkg::access_t acc;
  sram_port_pkg::wr_entry_t push_entry;
  sram_port_pkg::wr_entry_t head_entry;
  logic [sram_port_pkg::ENTRY_W-1:0] head_bits;
  logic [sram_port_pkg::BURST_W-1:0] step_cnt;
  logic [sram_port_pkg::BURST_W-1:0] burst_low;
  logic [sram_port_pkg::ADDR_W-1:0] acc_addr;
  logic [sram_port_pkg::DATA_W-1:0] fwd_data;
  logic drain_ok;
  logic run;
  logic selected;
  logic load;
  logic push_valid;
  logic fifo_in_ready;
  logic head_valid;
  logic drain_fire;

  // held or sleeping: nothing moves, not even the array writes
  assign drain_ok = ~clock_hold_n_in & ~sleep_request_in;
  assign run = drain_ok & fifo_in_ready;
  assign selected = ~chip_sel_0_n_in & chip_sel_1_in & ~chip_sel_2_n_in;
  assign load = ~advance_or_load_in;
  assign step_cnt = st_reg.cnt + sram_port_pkg::BURST_STEP;

  burst_step u_burst_step (
    .start_in(st_reg.base[1:0]),
    .step_in(step_cnt),
    .linear_order_sel_n_in(linear_order_sel_n_in),
    .addr_out(burst_low)
  );

  always_comb begin
    acc = sram_port_pkg::ACC_NONE;
    acc_addr = {st_reg.base[sram_port_pkg::ADDR_W-1:2], burst_low};
    if (load) begin
      acc_addr = addr_in;
      if (selected) begin
        acc = read_write_n_in ? sram_port_pkg::ACC_READ : sram_port_pkg::ACC_WRITE;
      end
    end else if (st_reg.active) begin
      acc = st_reg.is_write ? sram_port_pkg::ACC_WRITE : sram_port_pkg::ACC_READ;
    end
  end

  // ****************************************************************
  // late write capture and buffering
  // ****************************************************************
  // data follows the command by one run edge; all enables high aborts the write
  assign push_valid = run & st_reg.wr_pend & ~(&st_reg.wr_bw_n);
  assign push_entry.addr = st_reg.wr_addr;
  assign push_entry.bw_n = st_reg.wr_bw_n;
  assign push_entry.data = dq_in;
  assign head_entry = head_bits;
  assign drain_fire = head_valid & drain_ok;

  write_fifo #(
    .WIDTH(sram_port_pkg::ENTRY_W),
    .DEPTH(sram_port_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_entry),
    .out_valid_out(head_valid),
    .out_ready_in(drain_ok),
    .out_data_out(head_bits)
  );

  // ****************************************************************
  // storage lanes with forwarding of writes not yet stored
  // ****************************************************************
  genvar lane;
  generate
    for (lane = 0; lane < sram_port_pkg::LANES; lane = lane + 1) begin : g_lane
      logic [sram_port_pkg::LANE_W-1:0] cells [0:sram_port_pkg::WORDS-1];
      logic [sram_port_pkg::LANE_W-1:0] lane_q;
      logic [sram_port_pkg::LANE_W-1:0] lane_val;

      always_ff @(posedge clk_in) begin
        if (drain_fire && !head_entry.bw_n[lane]) begin
          cells[head_entry.addr] <= head_entry.data[lane*sram_port_pkg::LANE_W +:
                                                   sram_port_pkg::LANE_W];
        end
      end

      assign lane_q = cells[acc_addr];

      // newest write wins: the word on the bus, then the buffered one
      always_comb begin
        lane_val = lane_q;
        if (head_valid && head_entry.addr == acc_addr && !head_entry.bw_n[lane]) begin
          lane_val = head_entry.data[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
        end
        if (push_valid && push_entry.addr == acc_addr && !push_entry.bw_n[lane]) begin
          lane_val = dq_in[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
        end
      end

      assign fwd_data[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] = lane_val;
    end
  endgenerate

  // ****************************************************************
  // port sequencer
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    if (run) begin
      st_next.wr_pend = 1'b0;
      st_next.drive = 1'b0;
      case (acc)
        sram_port_pkg::ACC_NONE: begin
          if (load) begin
            st_next.active = 1'b0;
          end
        end
        sram_port_pkg::ACC_READ: begin
          if (load) begin
            st_next.active = 1'b1;
            st_next.is_write = 1'b0;
            st_next.base = addr_in;
            st_next.cnt = sram_port_pkg::BURST_FIRST;
          end else begin
            st_next.cnt = step_cnt;
          end
          st_next.drive = 1'b1;
          st_next.dq = fwd_data;
        end
        sram_port_pkg::ACC_WRITE: begin
          if (load) begin
            st_next.active = 1'b1;
            st_next.is_write = 1'b1;
            st_next.base = addr_in;
            st_next.cnt = sram_port_pkg::BURST_FIRST;
          end else begin
            st_next.cnt = step_cnt;
          end
          st_next.wr_pend = 1'b1;
          st_next.wr_addr = acc_addr;
          st_next.wr_bw_n = byte_write_n_in;
        end
        default: begin
          st_next = st_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= sram_port_pkg::PORT_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dq_out = st_reg.dq;
  // enable is gated without the clock; write data cycles never drive
  assign dq_oe_out = st_reg.drive & ~output_enable_n_in
                     & ~sleep_request_in;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_late_data;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_WRITE && byte_write_n_in != 2'h3)
      |=> (!run || (push_valid && push_entry.data == dq_in
                    && push_entry.addr == $past(acc_addr)
                    && push_entry.bw_n == $past(byte_write_n_in)));
  endproperty
  a_late_data: assert property (p_late_data) else $error("late data not taken");

  property p_abort;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_WRITE && byte_write_n_in == 2'h3) |=> !push_valid;
  endproperty
  a_abort: assert property (p_abort) else $error("aborted write was buffered");

  property p_hold_freeze;
    @(posedge clk_in) disable iff (sys_rst_in)
      clock_hold_n_in |=> $stable(st_reg);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("state moved while held");

  property p_hold_no_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      clock_hold_n_in |-> !drain_fire;
  endproperty
  a_hold_no_write: assert property (p_hold_no_write) else $error("write while held");

  property p_deselect_float;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && load && !selected) |=> (!dq_oe_out && !st_reg.drive);
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("drive deselected");

  property p_write_quiet;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_WRITE) |=> !dq_oe_out;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drive in write data");

  property p_read_next;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_READ) |=> (st_reg.drive && dq_out == $past(fwd_data));
  endproperty
  a_read_next: assert property (p_read_next) else $error("read data late or wrong");

  property p_load_base;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && load && selected) |=> (st_reg.base == $past(addr_in) && st_reg.cnt == 2'h0);
  endproperty
  a_load_base: assert property (p_load_base) else $error("start address not loaded");

  property p_burst_type;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && !load && st_reg.active) |=> (st_reg.is_write == $past(st_reg.is_write));
  endproperty
  a_burst_type: assert property (p_burst_type) else $error("burst changed direction");

  property p_wrap;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && !load && st_reg.active && st_reg.cnt == sram_port_pkg::BURST_LAST)
      |=> (st_reg.cnt == 2'h0 && st_reg.base == $past(st_reg.base));
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst did not wrap");

  property p_oe_gate;
    @(posedge clk_in) disable iff (sys_rst_in)
      (output_enable_n_in || !st_reg.drive) |-> !dq_oe_out;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("driving with enable off");

  property p_sleep_float;
    @(posedge clk_in) disable iff (sys_rst_in)
      sleep_request_in |-> (!dq_oe_out && !drain_fire);
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("driving while asleep");

  property p_burst_step;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && !load && st_reg.active) |=> (st_reg.cnt == 2'($past(st_reg.cnt) + 2'h1));
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst count not stepped");

  property p_advance_idle;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && !load && !st_reg.active) |=> (!st_reg.drive && !st_reg.wr_pend && !st_reg.active);
  endproperty
  a_advance_idle: assert property (p_advance_idle) else $error("idle advance acted");

  property p_load_dir;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && load && selected) |=> (st_reg.active && st_reg.is_write == !$past(read_write_n_in));
  endproperty
  a_load_dir: assert property (p_load_dir) else $error("wrong direction on load");

  property p_cov_read;
    @(posedge clk_in) disable iff (sys_rst_in) (run && acc == sram_port_pkg::ACC_READ);
  endproperty
  c_read: cover property (p_cov_read);

  property p_cov_wr_rd;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_WRITE) ##1 (run && acc == sram_port_pkg::ACC_READ);
  endproperty
  c_wr_rd: cover property (p_cov_wr_rd);

  property p_cov_wrap;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && !load && st_reg.active && st_reg.cnt == sram_port_pkg::BURST_LAST);
  endproperty
  c_wrap: cover property (p_cov_wrap);

  property p_cov_hold_read;
    @(posedge clk_in) disable iff (sys_rst_in) (st_reg.drive && clock_hold_n_in);
  endproperty
  c_hold_read: cover property (p_cov_hold_read);

  property p_cov_abort;
    @(posedge clk_in) disable iff (sys_rst_in)
      (run && acc == sram_port_pkg::ACC_WRITE && byte_write_n_in == 2'h3);
  endproperty
  c_abort: cover property (p_cov_abort);
endmodule

// File: core/sram_port_pkg.sv
// shared constants and carrier types for the late-write synchronous memory port
package sram_port_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int WORDS = 524288;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_LAST = 2'h3;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;

  // ****************************************************************
  // carriers and state
  // ****************************************************************
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} access_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bw_n;
    logic [DATA_W-1:0] data;
  } wr_entry_t;

  localparam int ENTRY_W = $bits(wr_entry_t);

  typedef struct packed {
    logic active;
    logic is_write;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] cnt;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_bw_n;
    logic drive;
    logic [DATA_W-1:0] dq;
  } port_state_t;

  localparam port_state_t PORT_STATE_RESET = '0;
endpackage

// File: core/write_fifo.sv
// write data buffer between the bus capture and the storage array
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic [WIDTH-1:0] slots [0:DEPTH-1];
  logic push;
  logic pop;

  assign in_ready_out = (st_reg.count != FULL_COUNT);
  assign out_valid_out = (st_reg.count != '0);
  assign out_data_out = slots[st_reg.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = PTR_W'(st_reg.wr + 1'b1);
    end
    if (pop) begin
      st_next.rd = PTR_W'(st_reg.rd + 1'b1);
    end
    if (push && !pop) begin
      st_next.count = (PTR_W+1)'(st_reg.count + 1'b1);
    end else if (pop && !push) begin
      st_next.count = (PTR_W+1)'(st_reg.count - 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      slots[st_reg.wr] <= in_data_in;
    end
  end
endmodule
